// [ofd_map.vh]
// Field positions, codes and reset values for the operand field decoder
`ifndef OFD_MAP_VH
`define OFD_MAP_VH

// ******************************
// Opcode byte fields
// ******************************
`define OFD_W_BIT        0
`define OFD_D_BIT        1
`define OFD_S_BIT        1
`define OFD_V_BIT        1
`define OFD_Z_BIT        0

// ******************************
// Address/operand byte fields
// ******************************
`define OFD_MODE_HI      7
`define OFD_MODE_LO      6
`define OFD_REG_HI       5
`define OFD_REG_LO       3
`define OFD_RM_HI        2
`define OFD_RM_LO        0
`define OFD_MODE_NODISP  2'h0
`define OFD_MODE_DISP8   2'h1
`define OFD_MODE_DISP16  2'h2
`define OFD_MODE_REG     2'h3
`define OFD_RM_DIRECT    3'h6

// ******************************
// Segment override prefix
// ******************************
`define OFD_PFX_TOP      3'h1
`define OFD_PFX_BOT      3'h6
`define OFD_SEG_EXTRA    2'h0
`define OFD_SEG_CODE     2'h1
`define OFD_SEG_STACK    2'h2
`define OFD_SEG_DATA     2'h3

// ******************************
// Immediate kinds
// ******************************
`define OFD_IMM_NONE     2'h0
`define OFD_IMM_BY_W     2'h1
`define OFD_IMM_BY_SW    2'h2
`define OFD_SW_WORD      2'h1
`define OFD_SW_SEXT      2'h3

// ******************************
// Flags word positions
// ******************************
`define OFD_FLG_CARRY    0
`define OFD_FLG_PARITY   2
`define OFD_FLG_AUX      4
`define OFD_FLG_ZERO     6
`define OFD_FLG_SIGN     7
`define OFD_FLG_TRAP     8
`define OFD_FLG_INTEN    9
`define OFD_FLG_DIR      10
`define OFD_FLG_OVF      11

// ******************************
// Reset values
// ******************************
`define OFD_RST_BYTE     8'h00
`define OFD_RST_WORD     16'h0000
`define OFD_RST_SEG      2'h3
`define OFD_COUNT_ONE    8'h01

`endif

// [ofd_ea_calc.v]
// Effective address and displacement formation from the addressing fields
`timescale 1ns/1ps
`default_nettype none
`include "ofd_map.vh"

module ofd_ea_calc (
  input  wire [1:0]  mode_in,     // Addressing form
  input  wire [2:0]  rm_in,       // Operand selector
  input  wire [7:0]  disp_lo_in,  // First displacement byte
  input  wire [7:0]  disp_hi_in,  // Second displacement byte
  input  wire [15:0] bx_in,       // base_register_b value
  input  wire [15:0] bp_in,       // base_pointer value
  input  wire [15:0] si_in,       // source_index value
  input  wire [15:0] di_in,       // destination_index value
  output reg  [15:0] disp_out,    // Address offset
  output reg  [15:0] ea_out       // effective_address
);

  reg [15:0] base;

  always @* begin
    disp_out = `OFD_RST_WORD;
    base     = `OFD_RST_WORD;
    case (mode_in)
      `OFD_MODE_NODISP: disp_out = `OFD_RST_WORD;
      `OFD_MODE_DISP8:  disp_out = {{8{disp_lo_in[7]}}, disp_lo_in};
      `OFD_MODE_DISP16: disp_out = {disp_hi_in, disp_lo_in};
      default:          disp_out = `OFD_RST_WORD;
    endcase
    case (rm_in)
      3'h0: base = bx_in + si_in;
      3'h1: base = bx_in + di_in;
      3'h2: base = bp_in + si_in;
      3'h3: base = bp_in + di_in;
      3'h4: base = si_in;
      3'h5: base = di_in;
      3'h6: base = bp_in;
      default: base = bx_in;
    endcase
    ea_out = base + disp_out;
    if (mode_in == `OFD_MODE_NODISP && rm_in == `OFD_RM_DIRECT) begin
      ea_out = {disp_hi_in, disp_lo_in};
    end
  end

endmodule // ofd_ea_calc

`default_nettype wire

// [ofd_operand_decoder.v]
// Operand field decoder: walks instruction bytes and decodes operand fields
`timescale 1ns/1ps
`default_nettype none
`include "ofd_map.vh"

// How it works
// - Direction bit 1 makes register field the destination, 0 the source.
// - Width bit 1 selects word operation, 0 selects byte operation.
// - Addressing form 11 makes the operand selector a register number.
// - Addressing form 00 gives zero offset and, except with selector 110, no displacement bytes.
// - Addressing form 01 takes one displacement byte, sign-extended to 16 bits.
// - Addressing form 10 takes two displacement bytes, low first, high:low.
// - Selectors 000-011 add a base and an index register to the offset.
// - Selectors 100-111 add one register to the offset.
// - Form 00 with selector 110 uses the two-byte direct address.
// - Displacement bytes follow the second byte, before immediate bytes.
// - Sign/width 01 takes a word immediate; 11 one byte sign-extended.
// - Count-select 0 gives count one, 1 gives the count low byte.
// - Repeat bit is compared with zero flag to continue repetition.
// - Prefix 001-seg-110 picks extra, code, stack or data segment.
// - Register codes map to word registers or low/high bytes.
// - Flags word packs overflow down to carry with gaps between.
// - Above/below compare unsigned; greater/less compare signed.
module ofd_operand_decoder (
  input  wire        ref_clk_in,       // 200 MHz clock
  input  wire        nrst_in,          // Synchronous reset, active low
  input  wire [7:0]  byte_in,          // Instruction byte from fetch queue
  input  wire        byte_valid_in,    // Byte present
  output wire        byte_ready_out,   // Decoder takes a byte this cycle
  input  wire        has_modrm_in,     // Opcode carries an address/operand byte
  input  wire [1:0]  imm_kind_in,      // Immediate kind, with the opcode byte
  input  wire        seg_dest_in,      // Opcode writes a segment from reg field
  input  wire [15:0] base_register_b_in,   // base_register_b
  input  wire [15:0] base_pointer_in,      // base_pointer
  input  wire [15:0] source_index_in,      // source_index
  input  wire [15:0] destination_index_in, // destination_index
  input  wire [15:0] count_register_in,    // count_register
  input  wire        overflow_flag_in,     // overflow_flag
  input  wire        direction_flag_in,    // direction_flag
  input  wire        int_enable_flag_in,   // Interrupt enable flag
  input  wire        trap_flag_in,         // trap_flag
  input  wire        sign_flag_in,         // sign_flag
  input  wire        zero_flag_in,         // zero_flag
  input  wire        aux_carry_flag_in,    // aux_carry_flag
  input  wire        parity_flag_in,       // parity_flag
  input  wire        carry_flag_in,        // carry_flag
  input  wire [3:0]  cond_code_in,         // Condition code to evaluate
  output reg         done_out,             // One-cycle pulse: results valid
  output reg         reg_is_dest_out,      // Register field is destination
  output reg         word_op_out,          // Word operation
  output reg         rm_is_reg_out,        // Selector names a register
  output reg  [2:0]  reg_idx_out,          // Register field register index
  output reg         reg_hi_byte_out,      // Register field is a high byte
  output reg  [2:0]  rm_idx_out,           // Selector register index
  output reg         rm_hi_byte_out,       // Selector register is a high byte
  output reg  [15:0] disp_out,             // Address offset
  output reg  [15:0] effective_address_out, // effective_address
  output reg  [15:0] imm_out,              // Immediate operand
  output reg  [7:0]  shift_count_out,      // Shift/rotate count
  output reg         seg_override_out,     // Segment override present
  output reg  [1:0]  seg_code_out,         // Overriding segment code
  output reg         cs_dest_err_out,      // Move into code segment seen
  output reg         rep_continue_out,     // Repetition continues
  output reg         cond_true_out,        // Condition holds
  output reg  [15:0] flags_word_out        // Flags as one word
);

  // ******************************
  // States
  // ******************************
  localparam [6:0] ST_OPC    = 7'h01;
  localparam [6:0] ST_MODRM  = 7'h02;
  localparam [6:0] ST_DISPLO = 7'h04;
  localparam [6:0] ST_DISPHI = 7'h08;
  localparam [6:0] ST_IMMLO  = 7'h10;
  localparam [6:0] ST_IMMHI  = 7'h20;
  localparam [6:0] ST_DONE   = 7'h40;

  reg [6:0]  state_q, state_d;
  reg [7:0]  opc_q;
  reg [7:0]  modrm_q;
  reg [7:0]  disp_lo_q;
  reg [7:0]  disp_hi_q;
  reg [7:0]  imm_lo_q;
  reg [7:0]  imm_hi_q;
  reg [1:0]  imm_kind_q;
  reg        has_modrm_q;
  reg        seg_dest_q;
  reg        pfx_q;
  reg [1:0]  pfx_seg_q;
  reg [1:0]  disp_len;
  reg        imm_two;
  reg        imm_sext;
  reg        cond_raw;

  wire        take = byte_valid_in & byte_ready_out;
  wire        is_pfx;
  wire [1:0]  mode = modrm_q[`OFD_MODE_HI:`OFD_MODE_LO];
  wire [1:0]  new_mode = byte_in[`OFD_MODE_HI:`OFD_MODE_LO];
  wire [2:0]  new_rm = byte_in[`OFD_RM_HI:`OFD_RM_LO];
  wire [2:0]  reg_f = modrm_q[`OFD_REG_HI:`OFD_REG_LO];
  wire [2:0]  rm_f = modrm_q[`OFD_RM_HI:`OFD_RM_LO];
  wire        wbit = opc_q[`OFD_W_BIT];
  wire [1:0]  sw = {opc_q[`OFD_S_BIT], opc_q[`OFD_W_BIT]};
  wire [15:0] ea_calc;
  wire [15:0] disp_calc;

  assign byte_ready_out = (state_q != ST_DONE);
  assign is_pfx = (byte_in[7:5] == `OFD_PFX_TOP) && (byte_in[2:0] == `OFD_PFX_BOT);

  // ******************************
  // Effective address unit
  // ******************************
  ofd_ea_calc u_ea (
    .mode_in    (mode),
    .rm_in      (rm_f),
    .disp_lo_in (disp_lo_q),
    .disp_hi_in (disp_hi_q),
    .bx_in      (base_register_b_in),
    .bp_in      (base_pointer_in),
    .si_in      (source_index_in),
    .di_in      (destination_index_in),
    .disp_out   (disp_calc),
    .ea_out     (ea_calc)
  );

  // ******************************
  // Byte counts
  // ******************************
  always @* begin
    disp_len = 2'h0;
    if (new_mode == `OFD_MODE_DISP8) begin
      disp_len = 2'h1;
    end else if (new_mode == `OFD_MODE_DISP16) begin
      disp_len = 2'h2;
    end else if (new_mode == `OFD_MODE_NODISP && new_rm == `OFD_RM_DIRECT) begin
      disp_len = 2'h2;
    end
    imm_two  = 1'b0;
    imm_sext = 1'b0;
    if (imm_kind_q == `OFD_IMM_BY_W) begin
      imm_two = wbit;
    end else if (imm_kind_q == `OFD_IMM_BY_SW) begin
      imm_two  = (sw == `OFD_SW_WORD);
      imm_sext = (sw == `OFD_SW_SEXT);
    end
  end

  // ******************************
  // Sequencer
  // ******************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OPC: begin
        if (take && !is_pfx) begin
          if (has_modrm_in) begin
            state_d = ST_MODRM;
          end else if (imm_kind_in != `OFD_IMM_NONE) begin
            state_d = ST_IMMLO;
          end else begin
            state_d = ST_DONE;
          end
        end
      end
      ST_MODRM: begin
        if (take) begin
          if (disp_len != 2'h0) begin
            state_d = ST_DISPLO;
          end else if (imm_kind_q != `OFD_IMM_NONE) begin
            state_d = ST_IMMLO;
          end else begin
            state_d = ST_DONE;
          end
        end
      end
      ST_DISPLO: begin
        if (take) begin
          if (mode != `OFD_MODE_DISP8) begin
            state_d = ST_DISPHI;
          end else if (imm_kind_q != `OFD_IMM_NONE) begin
            state_d = ST_IMMLO;
          end else begin
            state_d = ST_DONE;
          end
        end
      end
      ST_DISPHI: begin
        if (take) begin
          if (imm_kind_q != `OFD_IMM_NONE) begin
            state_d = ST_IMMLO;
          end else begin
            state_d = ST_DONE;
          end
        end
      end
      ST_IMMLO: if (take) state_d = imm_two ? ST_IMMHI : ST_DONE;
      ST_IMMHI: if (take) state_d = ST_DONE;
      ST_DONE: state_d = ST_OPC;
      default: state_d = ST_OPC;
    endcase
  end

  always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      state_q     <= ST_OPC;
      opc_q       <= `OFD_RST_BYTE;
      modrm_q     <= `OFD_RST_BYTE;
      disp_lo_q   <= `OFD_RST_BYTE;
      disp_hi_q   <= `OFD_RST_BYTE;
      imm_lo_q    <= `OFD_RST_BYTE;
      imm_hi_q    <= `OFD_RST_BYTE;
      imm_kind_q  <= `OFD_IMM_NONE;
      has_modrm_q <= 1'b0;
      seg_dest_q  <= 1'b0;
      pfx_q       <= 1'b0;
      pfx_seg_q   <= `OFD_RST_SEG;
    end else begin
      state_q <= state_d;
      if (state_q == ST_DONE) begin
        pfx_q <= 1'b0;
      end
      if (take) begin
        case (state_q)
          ST_OPC: begin
            if (is_pfx) begin
              pfx_q     <= 1'b1;
              pfx_seg_q <= byte_in[4:3];
            end else begin
              opc_q       <= byte_in;
              imm_kind_q  <= imm_kind_in;
              has_modrm_q <= has_modrm_in;
              seg_dest_q  <= seg_dest_in;
              modrm_q     <= `OFD_RST_BYTE;
              disp_lo_q   <= `OFD_RST_BYTE;
              disp_hi_q   <= `OFD_RST_BYTE;
              imm_lo_q    <= `OFD_RST_BYTE;
              imm_hi_q    <= `OFD_RST_BYTE;
            end
          end
          ST_MODRM:  modrm_q   <= byte_in;
          ST_DISPLO: disp_lo_q <= byte_in;
          ST_DISPHI: disp_hi_q <= byte_in;
          ST_IMMLO:  imm_lo_q  <= byte_in;
          ST_IMMHI:  imm_hi_q  <= byte_in;
          default:   opc_q     <= opc_q;
        endcase
      end
    end
  end

  // ******************************
  // Condition evaluation
  // ******************************
  always @* begin
    case (cond_code_in[3:1])
      3'h0: cond_raw = overflow_flag_in;
      3'h1: cond_raw = carry_flag_in;
      3'h2: cond_raw = zero_flag_in;
      3'h3: cond_raw = carry_flag_in | zero_flag_in;
      3'h4: cond_raw = sign_flag_in;
      3'h5: cond_raw = parity_flag_in;
      3'h6: cond_raw = sign_flag_in ^ overflow_flag_in;
      default: cond_raw = (sign_flag_in ^ overflow_flag_in) | zero_flag_in;
    endcase
  end

  // ******************************
  // Results
  // ******************************
  always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      done_out              <= 1'b0;
      reg_is_dest_out       <= 1'b0;
      word_op_out           <= 1'b0;
      rm_is_reg_out         <= 1'b0;
      reg_idx_out           <= 3'h0;
      reg_hi_byte_out       <= 1'b0;
      rm_idx_out            <= 3'h0;
      rm_hi_byte_out        <= 1'b0;
      disp_out              <= `OFD_RST_WORD;
      effective_address_out <= `OFD_RST_WORD;
      imm_out               <= `OFD_RST_WORD;
      shift_count_out       <= `OFD_COUNT_ONE;
      seg_override_out      <= 1'b0;
      seg_code_out          <= `OFD_RST_SEG;
      cs_dest_err_out       <= 1'b0;
      rep_continue_out      <= 1'b0;
      cond_true_out         <= 1'b0;
      flags_word_out        <= `OFD_RST_WORD;
    end else begin
      done_out         <= (state_q == ST_DONE);
      cond_true_out    <= cond_raw ^ cond_code_in[0];
      rep_continue_out <= (opc_q[`OFD_Z_BIT] == zero_flag_in);
      flags_word_out   <= `OFD_RST_WORD;
      flags_word_out[`OFD_FLG_OVF]    <= overflow_flag_in;
      flags_word_out[`OFD_FLG_DIR]    <= direction_flag_in;
      flags_word_out[`OFD_FLG_INTEN]  <= int_enable_flag_in;
      flags_word_out[`OFD_FLG_TRAP]   <= trap_flag_in;
      flags_word_out[`OFD_FLG_SIGN]   <= sign_flag_in;
      flags_word_out[`OFD_FLG_ZERO]   <= zero_flag_in;
      flags_word_out[`OFD_FLG_AUX]    <= aux_carry_flag_in;
      flags_word_out[`OFD_FLG_PARITY] <= parity_flag_in;
      flags_word_out[`OFD_FLG_CARRY]  <= carry_flag_in;
      if (state_q == ST_DONE) begin
        reg_is_dest_out <= opc_q[`OFD_D_BIT];
        word_op_out     <= wbit;
        rm_is_reg_out   <= has_modrm_q && (mode == `OFD_MODE_REG);
        // Byte codes 100-111 are the high halves of the first four registers
        reg_idx_out     <= wbit ? reg_f : {1'b0, reg_f[1:0]};
        reg_hi_byte_out <= ~wbit & reg_f[2];
        rm_idx_out      <= wbit ? rm_f : {1'b0, rm_f[1:0]};
        rm_hi_byte_out  <= ~wbit & rm_f[2];
        disp_out        <= disp_calc;
        effective_address_out <= ea_calc;
        if (imm_two) begin
          imm_out <= {imm_hi_q, imm_lo_q};
        end else if (imm_sext) begin
          imm_out <= {{8{imm_lo_q[7]}}, imm_lo_q};
        end else begin
          imm_out <= {8'h00, imm_lo_q};
        end
        shift_count_out <= opc_q[`OFD_V_BIT] ?
                           count_register_in[7:0] : `OFD_COUNT_ONE;
        seg_override_out <= pfx_q;
        seg_code_out     <= pfx_seg_q;
        // Flags the forbidden form so the execution side can trap it
        cs_dest_err_out  <= seg_dest_q && (reg_f[1:0] == `OFD_SEG_CODE);
      end
    end
  end

endmodule // ofd_operand_decoder

`default_nettype wire

// [ofd_ea_calc_dummy_never.v]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [ofd_fetch_model.sv]
// Fetch queue model that offers instruction bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module ofd_fetch_model (
  input  wire logic       ref_clk_in,    // Clock
  input  wire logic       nrst_in,       // Reset, active low
  input  wire logic       stall_in,      // Hold back the next byte
  input  wire logic       byte_ready_in, // Decoder takes a byte
  output var  logic [7:0] byte_out,      // Offered byte
  output var  logic       valid_out      // Byte present
);
  logic [7:0] q[$];
  // Offered byte is held until taken; an idle bus toggles so stale data never matches
  always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      valid_out <= 1'b0;
      byte_out <= 8'h00;
    end else begin
      if (valid_out && byte_ready_in) void'(q.pop_front());
      if (!valid_out || byte_ready_in) begin
        if (q.size() > 0 && !stall_in) begin
          valid_out <= 1'b1;
          byte_out <= q[0];
        end else begin
          valid_out <= 1'b0;
          byte_out <= ~byte_out;
        end
      end
    end
  end
endmodule // ofd_fetch_model
`default_nettype wire

// [ofd_dec_monitor.sv]
// Concurrent checks on the operand field decoder ports
`timescale 1ns/1ps
`default_nettype none
module ofd_dec_monitor (
  input wire logic        ref_clk_in, nrst_in, byte_ready_out, done_out, word_op_out,
  input wire logic        reg_is_dest_out, rm_is_reg_out, reg_hi_byte_out, rm_hi_byte_out,
  input wire logic        overflow_flag_in, direction_flag_in, int_enable_flag_in,
  input wire logic        trap_flag_in, sign_flag_in, zero_flag_in, aux_carry_flag_in,
  input wire logic        parity_flag_in, carry_flag_in, cond_true_out, seg_override_out,
  input wire logic        cs_dest_err_out,
  input wire logic [2:0]  reg_idx_out, rm_idx_out,
  input wire logic [3:0]  cond_code_in,
  input wire logic [7:0]  shift_count_out,
  input wire logic [15:0] count_register_in, effective_address_out, imm_out, flags_word_out
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  logic [15:0] flg;
  logic [8:0]  cv;
  logic [7:0]  cnt_lo;
  assign flg = {4'h0, overflow_flag_in, direction_flag_in, int_enable_flag_in, trap_flag_in,
                sign_flag_in, zero_flag_in, 1'b0, aux_carry_flag_in, 1'b0, parity_flag_in,
                1'b0, carry_flag_in};
  assign cv = {cond_code_in, overflow_flag_in, sign_flag_in, zero_flag_in, parity_flag_in,
               carry_flag_in};
  assign cnt_lo = count_register_in[7:0];
  function automatic logic cond_f(input logic [8:0] v);
    logic t;
    case (v[8:6])
      3'h0: t = v[4];
      3'h1: t = v[0];
      3'h2: t = v[2];
      3'h3: t = v[0] | v[2];
      3'h4: t = v[3];
      3'h5: t = v[1];
      3'h6: t = v[3] ^ v[4];
      default: t = (v[3] ^ v[4]) | v[2];
    endcase
    return t ^ v[5];
  endfunction
  a_flags_order: assert property ($past(nrst_in) |-> flags_word_out == $past(flg))
    else $error("flags word packed wrongly");
  a_cond_signed: assert property ($past(nrst_in) |-> cond_true_out == cond_f($past(cv)))
    else $error("condition result wrong");
  a_count_select: assert property (done_out |->
    shift_count_out == (reg_is_dest_out ? $past(cnt_lo) : 8'h01))
    else $error("shift count wrong");
  a_hold_decode: assert property ($past(nrst_in) && !done_out |->
    $stable(effective_address_out) && $stable(imm_out) && $stable(reg_idx_out))
    else $error("decode outputs moved without done");
  a_ready_done: assert property (!byte_ready_out |=> done_out)
    else $error("done did not follow the refusing cycle");
  a_done_pulse: assert property (done_out |-> byte_ready_out ##1 !done_out)
    else $error("done not a single pulse");
  a_byte_regs: assert property (done_out && !word_op_out |->
    !reg_idx_out[2] && (!rm_is_reg_out || !rm_idx_out[2]))
    else $error("byte register index out of range");
  a_word_regs: assert property (done_out && word_op_out |->
    !reg_hi_byte_out && (!rm_is_reg_out || !rm_hi_byte_out))
    else $error("word register marked as high byte");
  c_reg_form: cover property (done_out && rm_is_reg_out);
  c_override: cover property (done_out && seg_override_out);
  c_cs_dest: cover property (done_out && cs_dest_err_out);
  c_cond_hit: cover property (cond_true_out && cond_code_in[3]);
endmodule // ofd_dec_monitor
bind ofd_operand_decoder ofd_dec_monitor i_ofd_dec_monitor (.*);
`default_nettype wire

// [tb.sv]
// Self-checking bench for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        ref_clk_in, nrst_in, has_modrm_in, seg_dest_in, stall;
  logic [1:0]  imm_kind_in;
  logic [3:0]  cond_code_in;
  logic [15:0] base_register_b_in, base_pointer_in, source_index_in;
  logic [15:0] destination_index_in, count_register_in;
  logic        overflow_flag_in, direction_flag_in, int_enable_flag_in, trap_flag_in;
  logic        sign_flag_in, zero_flag_in, aux_carry_flag_in, parity_flag_in, carry_flag_in;
  wire  [7:0]  byte_in, shift_count_out;
  wire  [2:0]  reg_idx_out, rm_idx_out;
  wire  [1:0]  seg_code_out;
  wire  [15:0] disp_out, effective_address_out, imm_out, flags_word_out;
  wire         byte_valid_in, byte_ready_out, done_out, reg_is_dest_out, word_op_out;
  wire         rm_is_reg_out, reg_hi_byte_out, rm_hi_byte_out, seg_override_out;
  wire         cs_dest_err_out, rep_continue_out, cond_true_out;
  int          fail_count = 0;
  int          num_checks = 0;
  logic [31:0] seed = 32'h0000ccaf;
  logic [31:0] rc;
  ofd_operand_decoder i_ofd_operand_decoder (.*);
  ofd_fetch_model i_ofd_fetch_model (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .stall_in(stall), .byte_ready_in(byte_ready_out), .byte_out(byte_in),
    .valid_out(byte_valid_in));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] rmap(input logic [2:0] c, input logic w);
    return w ? {c, 1'b0} : {1'b0, c[1:0], c[2]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    rc = rnd();
    stall <= rc[1:0] == 2'h0;
    cond_code_in <= rc[7:4];
  end
  // ****
  // Main sequence
  // ****
  initial begin
    logic [31:0] r;
    logic [15:0] vb, vp, vs, vd, vc, dp, ea, im;
    logic [8:0]  fl;
    logic [7:0]  op, mr, d0, d1, i0, i1;
    logic [1:0]  kd, sg, md;
    logic        hm, sd, pf, dir;
    int          nd, ni, k;
    {nrst_in, has_modrm_in, seg_dest_in, imm_kind_in} = '0;
    {base_register_b_in, base_pointer_in, source_index_in, destination_index_in} = '0;
    count_register_in = '0;
    {overflow_flag_in, direction_flag_in, int_enable_flag_in, trap_flag_in, sign_flag_in,
     zero_flag_in, aux_carry_flag_in, parity_flag_in, carry_flag_in} = '0;
    repeat (16) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    @(negedge ref_clk_in);
    chk("done_out", 16'h0, done_out);
    chk("shift_count_out", 16'h1, shift_count_out);
    chk("seg_code_out", 16'h3, seg_code_out);
    $display("test reset done");
    for (int n = 0; n < 300; n++) begin
      r = rnd();
      op = r[7:0];
      mr = r[15:8];
      hm = r[16];
      kd = r[18:17] % 3;
      sd = r[19];
      pf = r[20];
      sg = r[22:21];
      if (op[7:5] == 3'h1 && op[2:0] == 3'h6) op[7] = 1'b1;
      r = rnd();
      {d1, d0, i1, i0} = r;
      r = rnd();
      {vb, vp} = r;
      r = rnd();
      {vs, vd} = r;
      r = rnd();
      vc = r[15:0];
      fl = r[24:16];
      @(posedge ref_clk_in);
      has_modrm_in <= hm;
      imm_kind_in <= kd;
      seg_dest_in <= sd;
      {base_register_b_in, base_pointer_in, source_index_in} <= {vb, vp, vs};
      {destination_index_in, count_register_in} <= {vd, vc};
      {overflow_flag_in, direction_flag_in, int_enable_flag_in, trap_flag_in, sign_flag_in,
       zero_flag_in, aux_carry_flag_in, parity_flag_in, carry_flag_in} <= fl;
      md = mr[7:6];
      dir = hm && md == 2'h0 && mr[2:0] == 3'h6;
      nd = !hm ? 0 : (md == 2'h1) ? 1 : (md == 2'h2 || dir) ? 2 : 0;
      ni = (kd == 2'h1) ? (op[0] ? 2 : 1) : (kd == 2'h2) ? (op[1:0] == 2'h1 ? 2 : 1) : 0;
      @(negedge ref_clk_in);
      if (pf) i_ofd_fetch_model.q.push_back({3'h1, sg, 3'h6});
      i_ofd_fetch_model.q.push_back(op);
      if (hm) i_ofd_fetch_model.q.push_back(mr);
      if (nd > 0) i_ofd_fetch_model.q.push_back(d0);
      if (nd > 1) i_ofd_fetch_model.q.push_back(d1);
      if (ni > 0) i_ofd_fetch_model.q.push_back(i0);
      if (ni > 1) i_ofd_fetch_model.q.push_back(i1);
      k = 0;
      while (done_out !== 1'b1) begin
        @(negedge ref_clk_in);
        k++;
        if (k > 80) begin
          fail_count++;
          $display("ERROR done_out expected 1 seen none");
          end_of_test();
        end
      end
      dp = (md == 2'h1) ? {{8{d0[7]}}, d0} : (md == 2'h2) ? {d1, d0} : 16'h0;
      case (mr[2:0])
        3'h0: ea = vb + vs;
        3'h1: ea = vb + vd;
        3'h2: ea = vp + vs;
        3'h3: ea = vp + vd;
        3'h4: ea = vs;
        3'h5: ea = vd;
        3'h6: ea = vp;
        default: ea = vb;
      endcase
      ea = dir ? {d1, d0} : ea + dp;
      im = (ni == 2) ? {i1, i0} : (kd == 2'h2 && op[1:0] == 2'h3) ? {{8{i0[7]}}, i0} : i0;
      chk("reg_is_dest_out", op[1], reg_is_dest_out);
      chk("word_op_out", op[0], word_op_out);
      chk("shift_count_out", op[1] ? vc[7:0] : 8'h01, shift_count_out);
      chk("rep_continue_out", op[0] == fl[3], rep_continue_out);
      chk("seg_override_out", pf, seg_override_out);
      if (pf) chk("seg_code_out", sg, seg_code_out);
      if (ni > 0) chk("imm_out", im, imm_out);
      if (hm) begin
        chk("rm_is_reg_out", md == 2'h3, rm_is_reg_out);
        chk("reg_map", rmap(mr[5:3], op[0]), {reg_idx_out, reg_hi_byte_out});
        chk("cs_dest_err_out", sd && mr[4:3] == 2'h1, cs_dest_err_out);
        if (md == 2'h3) chk("rm_map", rmap(mr[2:0], op[0]), {rm_idx_out, rm_hi_byte_out});
        if (md != 2'h3 && !dir) chk("disp_out", dp, disp_out);
        if (md != 2'h3) chk("effective_address_out", ea, effective_address_out);
      end
    end
    $display("test random_instr done");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
